// File: pkg/sac_pkg.sv
package sac_pkg;

    // Core clock and internal conversion oscillator.
    localparam int CLK_HZ      = 250_000_000;
    localparam int OSC_HZ      = 11_500_000;
    // Rounded up so the internal conversion clock never runs faster than nominal.
    localparam int OSC_DIV_DEF = (CLK_HZ + OSC_HZ - 1) / OSC_HZ;

    // Conversion timing in conversion-clock cycles.
    localparam int CONV_CYCLES = 18;
    localparam int ACQ_CYCLES  = 3;

    // Converter shape.
    localparam int NUM_CH_DEF  = 8;
    localparam int RES_BITS    = 16;

    // Serial frame layout.
    localparam int CMD_BITS    = 4;
    localparam int CFG_BITS    = 12;
    localparam int FRAME_BITS  = 16;

    // Configuration word fields.
    localparam int CFG_SEQ_POS  = 11;
    localparam int CFG_CLK_POS  = 10;
    localparam int CFG_TRIG_POS = 9;
    localparam int CFG_PD_POS   = 2;
    localparam int CFG_PD_BITS  = 2;
    localparam logic [11:0] CFG_RESET = 12'h200;

    // Command nibble codes; with sequencing off, a nibble with its top bit clear selects a channel.
    localparam logic [3:0] CMD_WAKE    = 4'h8;
    localparam logic [3:0] CMD_READ    = 4'h9;
    localparam logic [3:0] CMD_WR_CFG  = 4'hA;
    localparam logic [3:0] CMD_DEFAULT = 4'hF;

    typedef enum logic [1:0] {PD_NONE, PD_NAP, PD_DEEP, PD_AUTO_NAP} sac_pd_t;
    typedef enum logic {ST_ACQ, ST_CONV} sac_st_t;

endpackage

// File: design/sac_link.sv
`timescale 1ns/100ps
module sac_link
    import sac_pkg::*;
(
    // Serial link pins
    input  wire logic                  sclk,
    input  wire logic                  cs_n,
    input  wire logic                  sdi,
    output logic                       sdo,
    // Reset
    input  wire logic                  rst,
    // Word sent to the host, held stable while the frame runs
    input  wire logic [RES_BITS-1:0]   tx_word,
    // Frame contents, stable once the bit clock stops
    output logic [CMD_BITS-1:0]        cmd,
    output logic [FRAME_BITS-1:0]      word,
    output logic [4:0]                 len
);

    typedef struct packed {
        logic [FRAME_BITS-1:0] shift;
        logic [CMD_BITS-1:0]   cmd;
        logic [FRAME_BITS-1:0] word;
        logic [4:0]            len;
    } sac_link_t;

    localparam sac_link_t LINK_RST = '{default: '0};
    localparam logic [4:0] LAST_BIT = 5'(FRAME_BITS);
    localparam logic [4:0] CMD_LAST = 5'(CMD_BITS - 1);
    localparam logic [4:0] WORD_LAST = 5'(FRAME_BITS - 1);

    sac_link_t  l_q;
    sac_link_t  l_d;
    logic [4:0] cnt_q;

    // The bit counter is cleared by the chip select itself, since the bit clock
    // does not run between frames.
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            cnt_q <= '0;
        end else if (cnt_q != LAST_BIT) begin
            cnt_q <= cnt_q + 5'h01;
        end
    end

    always_comb begin
        l_d = l_q;
        l_d.shift = {l_q.shift[FRAME_BITS-2:0], sdi};
        if (cnt_q == CMD_LAST) begin
            l_d.cmd = {l_q.shift[CMD_BITS-2:0], sdi}; // RULE20
        end
        if (cnt_q == WORD_LAST) begin
            l_d.word = {l_q.shift[FRAME_BITS-2:0], sdi}; // RULE20
        end
        if (cnt_q != LAST_BIT) begin
            l_d.len = cnt_q + 5'h01;
        end
    end

    // Input is sampled on the falling edge of the bit clock.
    always_ff @(negedge sclk or posedge rst) begin
        if (rst) begin
            l_q <= LINK_RST;
        end else begin
            l_q <= l_d; // RULE16
        end
    end

    // Each bit changes after a falling edge and is valid at the next one, which
    // suits a host that samples on falling edges.
    assign sdo  = cnt_q[4] ? 1'b0 : tx_word[~cnt_q[3:0]]; // RULE16 RULE17
    assign cmd  = l_q.cmd;
    assign word = l_q.word;
    assign len  = l_q.len;

endmodule

// File: design/sac_top.sv
`timescale 1ns/100ps
// What this block does and what its host must do
// RULE1: Conversion lasts exactly 18 conversion-clock cycles.
// RULE2: Acquisition lasts at least 3 cycles first.
// RULE3: Host spaces strobes by at least 21 cycles.
// RULE4: Conversion clock is oscillator or bit clock.
// RULE5: Manual mode takes channel from command nibble.
// RULE6: Auto mode starts from last completed channel.
// RULE7: Auto mode steps channels in internal order.
// RULE8: Strobe falling edge starts conversion when manual.
// RULE9: Auto trigger free-runs and ignores the strobe.
// RULE10: Sampling reads current result, converting reads previous.
// RULE11: Host reads each result within one period.
// RULE12: Eight inputs, 16-bit results, 500 ksps.
// RULE13: Three power-down modes: nap, deep, auto-nap.
// RULE14: Host controller acts as bus master.
// RULE15: Host picks clocking by polarity and phase.
// RULE16: Data launched and sampled on bit clock falling.
// RULE17: Host uses polarity and phase 00 or 11.
// RULE18: Host bit clock comes from its divider.
// RULE19: Host bit clock stays at or below 40 MHz.
// RULE20: Nibble command, plus 12 bits for configuration.
// RULE21: Status drops at conversion end, rises on select.
// RULE22: Host frames every transfer with chip select low.
// RULE23: Host starts reading on falling status edge.
module sac_top
    import sac_pkg::*;
#(
    parameter int NUM_CH  = NUM_CH_DEF,
    parameter int OSC_DIV = OSC_DIV_DEF
) (
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  rst,
    // Serial link
    input  wire logic                  sclk,
    input  wire logic                  cs_n,
    input  wire logic                  sdi,
    output logic                       sdo,
    // Conversion control
    input  wire logic                  conversion_strobe,
    output logic                       status_n,
    // Converter core
    input  wire logic [RES_BITS-1:0]   core_data,
    output logic [$clog2(NUM_CH)-1:0]  mux_sel,
    output logic                       hold,
    output sac_pd_t                    power_mode
);

    localparam int CHW = $clog2(NUM_CH);
    localparam int OW  = $clog2(OSC_DIV);
    localparam logic [OW-1:0]  OSC_LAST  = OW'(OSC_DIV - 1);
    localparam logic [CHW-1:0] CH_LAST   = CHW'(NUM_CH - 1);
    localparam logic [4:0]     CONV_LAST = 5'(CONV_CYCLES - 1);
    localparam logic [4:0]     ACQ_LAST  = 5'(ACQ_CYCLES - 1);
    localparam logic [4:0]     ACQ_N     = 5'(ACQ_CYCLES);
    localparam logic [4:0]     CMD_LEN   = 5'(CMD_BITS);
    localparam logic [4:0]     FULL_LEN  = 5'(FRAME_BITS);

    typedef struct packed {
        sac_st_t               st;
        logic [4:0]            cnt;
        logic [OW-1:0]         osc;
        logic [2:0]            cs_s;
        logic [2:0]            sclk_s;
        logic [2:0]            stb_s;
        logic [CFG_BITS-1:0]   cfg;
        logic [CHW-1:0]        ch;
        logic [CHW-1:0]        last_ch;
        logic [RES_BITS-1:0]   result;
        logic [RES_BITS-1:0]   tx;
        logic                  status_n;
        logic                  hold;
    } sac_main_t;

    localparam sac_main_t MAIN_RST = '{
        st:       ST_ACQ,
        cnt:      '0,
        osc:      '0,
        cs_s:     3'h7,
        sclk_s:   3'h0,
        stb_s:    3'h7,
        cfg:      CFG_RESET,
        ch:       '0,
        last_ch:  '0,
        result:   '0,
        tx:       '0,
        status_n: 1'b1,
        hold:     1'b0
    };

    sac_main_t s_q;
    sac_main_t s_d;

    logic [CMD_BITS-1:0]   cmd_w;
    logic [FRAME_BITS-1:0] word_w;
    logic [4:0]            len_w;

    logic cs_fall;
    logic frame_end;
    logic sclk_fall;
    logic stb_fall;
    logic osc_tick;
    logic tick;
    logic seq_on;
    logic trig_pin;
    logic acq_done;
    logic start;
    logic conv_end;
    logic [CFG_BITS-1:0] new_cfg;

    sac_link u_link (
        .sclk    (sclk),
        .cs_n    (cs_n),
        .sdi     (sdi),
        .sdo     (sdo),
        .rst     (rst),
        .tx_word (s_q.tx),
        .cmd     (cmd_w),
        .word    (word_w),
        .len     (len_w)
    );

    // Only the second and third synchroniser stages are looked at here.
    assign cs_fall   = s_q.cs_s[2] & ~s_q.cs_s[1];
    assign frame_end = ~s_q.cs_s[2] & s_q.cs_s[1]; // RULE22
    assign sclk_fall = s_q.sclk_s[2] & ~s_q.sclk_s[1];
    assign stb_fall  = s_q.stb_s[2] & ~s_q.stb_s[1];
    assign osc_tick  = (s_q.osc == OSC_LAST);
    assign seq_on    = s_q.cfg[CFG_SEQ_POS];
    assign trig_pin  = s_q.cfg[CFG_TRIG_POS];
    // With the bit clock selected, conversions only advance while the host clocks.
    assign tick      = s_q.cfg[CFG_CLK_POS] ? sclk_fall : osc_tick; // RULE4
    assign acq_done  = (s_q.cnt >= ACQ_N); // RULE2
    // Strobes that arrive too early are dropped rather than cutting sampling short.
    assign start     = (s_q.st == ST_ACQ) && (trig_pin ? (stb_fall && acq_done) // RULE3 RULE8
                     : (tick && s_q.cnt >= ACQ_LAST)); // RULE9
    assign conv_end  = (s_q.st == ST_CONV) && tick && (s_q.cnt == CONV_LAST); // RULE1
    assign new_cfg   = word_w[CFG_BITS-1:0];

    always_comb begin
        s_d = s_q;
        s_d.cs_s   = {s_q.cs_s[1:0], cs_n};
        s_d.sclk_s = {s_q.sclk_s[1:0], sclk};
        s_d.stb_s  = {s_q.stb_s[1:0], conversion_strobe};
        s_d.osc    = osc_tick ? '0 : s_q.osc + 1'b1;
        // The result shown to the host is frozen for the length of a frame.
        if (s_q.cs_s[1]) begin
            s_d.tx = s_q.result; // RULE10 RULE11
        end
        if (cs_fall) begin
            s_d.status_n = 1'b1; // RULE21
        end
        case (s_q.st)
            ST_ACQ: begin
                if (start) begin
                    s_d.st   = ST_CONV;
                    s_d.cnt  = '0;
                    s_d.hold = 1'b1;
                end else if (tick && !acq_done) begin
                    s_d.cnt = s_q.cnt + 5'h01; // RULE2
                end
            end
            ST_CONV: begin
                if (conv_end) begin
                    s_d.st       = ST_ACQ;
                    s_d.cnt      = '0;
                    s_d.hold     = 1'b0;
                    s_d.result   = core_data; // RULE10 RULE12
                    s_d.last_ch  = s_q.ch;
                    s_d.status_n = 1'b0; // RULE21 RULE23
                    if (seq_on) begin
                        s_d.ch = (s_q.ch == CH_LAST) ? '0 : s_q.ch + 1'b1; // RULE7
                    end
                end else if (tick) begin
                    s_d.cnt = s_q.cnt + 5'h01; // RULE1
                end
            end
            default: begin
                s_d.st  = ST_ACQ;
                s_d.cnt = '0;
            end
        endcase
        // A frame is decoded once chip select has returned high.
        if (frame_end && len_w >= CMD_LEN) begin
            if (!cmd_w[CMD_BITS-1] && !seq_on) begin
                s_d.ch = CHW'(cmd_w[CMD_BITS-2:0]); // RULE5 RULE7
            end else if (cmd_w == CMD_WAKE) begin
                s_d.cfg[CFG_PD_POS +: CFG_PD_BITS] = CFG_PD_BITS'(PD_NONE); // RULE13
            end else if (cmd_w == CMD_DEFAULT) begin
                s_d.cfg = CFG_RESET;
            end else if (cmd_w == CMD_WR_CFG && len_w == FULL_LEN) begin
                s_d.cfg = new_cfg; // RULE20
                if (new_cfg[CFG_SEQ_POS] && !seq_on) begin
                    s_d.ch = s_q.last_ch; // RULE6
                end
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_q <= MAIN_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign mux_sel    = s_q.ch;
    assign hold       = s_q.hold;
    assign status_n   = s_q.status_n;
    assign power_mode = sac_pd_t'(s_q.cfg[CFG_PD_POS +: CFG_PD_BITS]); // RULE13

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    conv_length_a: assert property ( // RULE1
        (s_q.st == ST_CONV && s_d.st == ST_ACQ) |-> (s_q.cnt == CONV_LAST && tick)
    ) else $error("conversion ended before its full cycle count");

    acq_min_a: assert property ( // RULE2
        (s_q.st == ST_ACQ && s_d.st == ST_CONV) |-> (s_q.cnt >= ACQ_LAST && (tick || acq_done))
    ) else $error("conversion began before sampling was long enough");

    clk_select_a: assert property ( // RULE4
        (!tick && s_q.st == ST_CONV) |=> $stable(s_q.cnt)
    ) else $error("conversion count moved without a conversion clock");

    manual_chan_a: assert property ( // RULE5
        (frame_end && len_w >= CMD_LEN && !cmd_w[CMD_BITS-1] && !seq_on)
        |=> (s_q.ch == CHW'($past(cmd_w[CMD_BITS-2:0])))
    ) else $error("manual channel command not applied");

    auto_first_a: assert property ( // RULE6
        (!seq_on ##1 seq_on) |-> (s_q.ch == $past(s_q.last_ch))
    ) else $error("sequencing did not start at last converted channel");

    auto_step_a: assert property ( // RULE7
        (conv_end && seq_on && !frame_end && s_q.ch != CH_LAST)
        |=> (s_q.ch == $past(s_q.ch) + 1'b1)
    ) else $error("automatic channel order not followed");

    strobe_start_a: assert property ( // RULE8
        (trig_pin && stb_fall && s_q.st == ST_ACQ && acq_done) |=> (s_q.st == ST_CONV && hold)
    ) else $error("strobe falling edge did not start a conversion");

    strobe_ignore_a: assert property ( // RULE9
        (!trig_pin && s_q.st == ST_ACQ && !tick) |=> (s_q.st == ST_ACQ)
    ) else $error("free-running trigger started off a conversion clock");

    result_hold_a: assert property ( // RULE10
        (s_q.st == ST_CONV && !conv_end) |=> $stable(s_q.result)
    ) else $error("result changed in the middle of a conversion");

    result_take_a: assert property ( // RULE10
        conv_end |=> (s_q.result == $past(core_data) && !status_n)
    ) else $error("finished conversion did not publish its result");

    status_rise_a: assert property ( // RULE21
        (cs_fall && !conv_end) |=> status_n
    ) else $error("status did not return high after chip select fell");

    conv_end_c: cover property (conv_end ##1 (s_q.st == ST_ACQ));
    cfg_write_c: cover property (frame_end && cmd_w == CMD_WR_CFG && len_w == FULL_LEN);
    chan_wrap_c: cover property (conv_end && seq_on && s_q.ch == CH_LAST);
    strobe_c: cover property (trig_pin && stb_fall && s_q.st == ST_ACQ && acq_done);

endmodule

// File: test/sac_host.sv
`timescale 1ns/100ps
module sac_host (
    // Serial link pins
    output logic      sclk,
    output logic      cs_n,
    output logic      sdi,
    input  wire logic sdo
);
    initial begin
        sclk = 1'h0;
        cs_n = 1'h1;
        sdi  = 1'h0;
    end

    // Master in mode 00 at 48 ns a bit; the bit clock stands still low between frames.
    task automatic xfer(input int n, input logic [15:0] w, output logic [15:0] r);
        r = 16'h0000;
        cs_n = 1'h0;
        #24;
        for (int i = 0; i < n; i++) begin
            #11.7;
            sclk = 1'h1;
            sdi  = w[15-i];
            #24;
            // Taken just before the falling edge, while the bit still stands.
            r = {r[14:0], sdo};
            sclk = 1'h0;
            #12.3;
        end
        // A released data line must not keep showing its last bit.
        sdi = ~sdi;
        #12;
        cs_n = 1'h1;
        #24;
    endtask
endmodule

// File: test/sac_top_tb.sv
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); miscompares++; end end
module sac_top_tb;
    import sac_pkg::*;
    localparam int DIV = 3;
    logic                clock;
    logic                rst;
    logic                sclk;
    logic                cs_n;
    logic                sdi;
    logic                sdo;
    logic                conversion_strobe;
    logic                status_n;
    logic                hold;
    logic [RES_BITS-1:0] core_data;
    logic [2:0]          mux_sel;
    sac_pd_t             power_mode;
    logic [15:0]         rd;
    int                  miscompares = 0;
    int                  checked = 0;
    int                  cycles = 0;

    sac_top #(.NUM_CH(8), .OSC_DIV(DIV)) u_dut (.clock(clock), .rst(rst), .sclk(sclk),
        .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .conversion_strobe(conversion_strobe),
        .status_n(status_n), .core_data(core_data), .mux_sel(mux_sel), .hold(hold),
        .power_mode(power_mode));
    sac_host u_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

    initial clock = 1'h0;
    always #2 clock = ~clock;

    // Each channel gives a distinct result so a wrong channel shows in the read word.
    function automatic logic [15:0] exp_res(input logic [2:0] ch);
        return {12'hC3A, 1'h0, ch};
    endfunction

    always @(posedge clock) begin
        core_data <= exp_res(mux_sel);
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            complete_run();
        end
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic frame(input int n, input logic [15:0] w);
        u_host.xfer(n, w, rd);
        repeat (6) @(negedge clock);
    endtask

    task automatic strobe;
        @(posedge clock);
        conversion_strobe <= 1'h0;
        // Released once the conversion shows, so callers time it from its start.
        for (int k = 0; k < 12 && hold !== 1'h1; k++) begin
            @(negedge clock);
        end
        @(posedge clock);
        conversion_strobe <= 1'h1;
    endtask

    task automatic wait_hold(input logic v);
        int n;
        n = 0;
        while (hold !== v && n < 2000) begin
            @(negedge clock);
            n++;
        end
        `CHK("hold", v, hold)
    endtask

    task automatic t_reset;
        `CHK("status_n", 1'h1, status_n)
        `CHK("hold", 1'h0, hold)
        `CHK("mux_sel", 3'h0, mux_sel)
        `CHK("power_mode", PD_NONE, power_mode)
        $display("test reset done");
    endtask

    task automatic t_manual;
        int n;
        frame(4, 16'h5000);
        `CHK("mux_sel", 3'h5, mux_sel)
        strobe();
        wait_hold(1'h1);
        n = 0;
        while (hold === 1'h1 && n < 200) begin
            @(negedge clock);
            n++;
        end
        `CHK("conv length", 1'h1, n >= 17 * DIV && n <= 18 * DIV + 1)
        `CHK("status_n", 1'h0, status_n)
        frame(16, {CMD_READ, 12'h000});
        `CHK("result", exp_res(3'h5), rd)
        `CHK("status_n", 1'h1, status_n)
        frame(4, 16'h2000);
        strobe();
        wait_hold(1'h1);
        // Read while converting: the word still carries the channel five result.
        frame(16, {CMD_READ, 12'h000});
        `CHK("prev result", exp_res(3'h5), rd)
        wait_hold(1'h0);
        $display("test manual done");
    endtask

    task automatic t_auto_trig;
        int n;
        int m;
        frame(16, {CMD_WR_CFG, 12'h000});
        wait_hold(1'h0);
        wait_hold(1'h1);
        n = 0;
        m = 0;
        while (hold === 1'h1 && n < 300) begin
            @(negedge clock);
            n++;
        end
        // A strobe during free-running sampling must not shorten it.
        @(posedge clock);
        conversion_strobe <= 1'h0;
        while (hold === 1'h0 && m < 300) begin
            @(negedge clock);
            m++;
        end
        @(posedge clock);
        conversion_strobe <= 1'h1;
        `CHK("acq length", 3 * DIV, m)
        `CHK("auto period", 21 * DIV, n + m)
        $display("test auto trigger done");
    endtask

    task automatic t_sequence;
        frame(16, {CMD_WR_CFG, 12'h200});
        repeat (100) @(negedge clock);
        frame(16, {CMD_WR_CFG, 12'hA00});
        `CHK("seq start", 3'h2, mux_sel)
        frame(4, 16'h6000);
        `CHK("seq nibble", 3'h2, mux_sel)
        for (int k = 0; k < 8; k++) begin
            strobe();
            wait_hold(1'h1);
            `CHK("seq channel", 3'(2 + k), mux_sel)
            wait_hold(1'h0);
            repeat (4 * DIV) @(negedge clock);
        end
        $display("test sequence done");
    endtask

    task automatic t_power;
        for (int p = 0; p < 4; p++) begin
            frame(16, {CMD_WR_CFG, 12'h200 | 12'(p << 2)});
            `CHK("power_mode", sac_pd_t'(2'(p)), power_mode)
        end
        frame(8, {CMD_WR_CFG, 12'h204});
        `CHK("short write", PD_AUTO_NAP, power_mode)
        frame(4, {CMD_WAKE, 12'h000});
        `CHK("wake", PD_NONE, power_mode)
        $display("test power done");
    endtask

    task automatic t_sclk_clock;
        frame(16, {CMD_WR_CFG, 12'h600});
        frame(4, {CMD_READ, 12'h000});
        strobe();
        wait_hold(1'h1);
        frame(16, {CMD_READ, 12'h000});
        `CHK("hold sclk", 1'h1, hold)
        frame(4, {CMD_READ, 12'h000});
        `CHK("hold sclk", 1'h0, hold)
        `CHK("status_n", 1'h0, status_n)
        $display("test link clock done");
    endtask

    initial begin
        rst = 1'h1;
        conversion_strobe = 1'h1;
        repeat (6) @(posedge clock);
        rst <= 1'h0;
        repeat (6) @(negedge clock);
        t_reset();
        t_manual();
        t_auto_trig();
        t_sequence();
        t_power();
        t_sclk_clock();
        complete_run();
    end
endmodule
